// File: design/bct_apb_if.sv
// APB slave decoder turning transfers into one-cycle register strobes
`timescale 1ns/1ps
module bct_apb_if import bct_pkg::*; (
   input  wire logic         clk,     // System clock
   input  wire logic         rst_n,   // Synchronised reset, active low
   input  wire bct_apb_req_s req,     // APB request
   output bct_acc_s          acc,     // Access strobes
   output logic              hit,     // Address is mapped
   output logic              fire     // Access phase edge
);

   // Whole state: nothing beyond one flag marking a taken access
   typedef struct packed {
      logic busy;   // Unused holder so the idiom stays uniform
   } bct_if_s;

   bct_if_s st_q;   // Registered state
   bct_if_s st_d;   // Next state

   // Mapped address test
   function automatic logic bct_mapped(input logic [11:0] a);
      bct_mapped = (a <= BCT_ADDR_GIC) && (a[1:0] == 2'h0);
   endfunction

   // Decode strobes; every access completes with pready high
   always_comb begin
      logic wr;
      wr = req.psel & req.penable & req.pwrite;
      fire = req.psel & req.penable;
      hit = bct_mapped(req.paddr);
      acc.wdata    = req.pwdata[7:0];
      acc.wr_low   = wr && req.paddr == BCT_ADDR_LOW;
      acc.wr_high  = wr && req.paddr == BCT_ADDR_HIGH;
      acc.rd_low   = fire && !req.pwrite && req.paddr == BCT_ADDR_LOW;
      acc.wr_ctrl  = wr && req.paddr == BCT_ADDR_CTRL;
      acc.wr_flags = wr && req.paddr == BCT_ADDR_FLAGS;
      acc.wr_ena   = wr && req.paddr == BCT_ADDR_ENA;
      acc.wr_prio  = wr && req.paddr == BCT_ADDR_PRIO;
      acc.wr_gic   = wr && req.paddr == BCT_ADDR_GIC;
      st_d.busy    = fire;
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q.busy <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule

// File: design/bct_pkg.sv
// Package with register map, field layout and shared types of the buffered counter
package bct_pkg;

   // Register byte addresses on APB
   localparam logic [11:0] BCT_ADDR_LOW    = 12'h000;   // Count low byte
   localparam logic [11:0] BCT_ADDR_HIGH   = 12'h004;   // High byte / holding buffer
   localparam logic [11:0] BCT_ADDR_CTRL   = 12'h008;   // Counter control
   localparam logic [11:0] BCT_ADDR_FLAGS  = 12'h00c;   // Peripheral flags one
   localparam logic [11:0] BCT_ADDR_ENA    = 12'h010;   // Peripheral enables one
   localparam logic [11:0] BCT_ADDR_PRIO   = 12'h014;   // Peripheral priority one
   localparam logic [11:0] BCT_ADDR_GIC    = 12'h018;   // Global interrupt control

   // Control field positions
   localparam int BCT_CTRL_RUN_BIT   = 0;   // Counter run
   localparam int BCT_CTRL_SRC_BIT   = 1;   // Count source select
   localparam int BCT_CTRL_SYNC_BIT  = 2;   // External sync bypass
   localparam int BCT_CTRL_OSC_BIT   = 3;   // Crystal oscillator enable
   localparam int BCT_CTRL_PS_LSB    = 4;   // Prescale select low bit
   localparam int BCT_CTRL_AUX_BIT   = 6;   // System clock from aux osc (read only)
   localparam int BCT_CTRL_WIDE_BIT  = 7;   // Wide access enable
   localparam int BCT_OVF_BIT        = 0;   // Overflow bit in flags/enables/priority
   localparam int BCT_GIC_GIE_BIT    = 7;   // Global interrupt enable
   localparam int BCT_GIC_PEIE_BIT   = 6;   // Peripheral interrupt enable

   // Reset values
   localparam logic [7:0]  BCT_CTRL_RST  = 8'h00;   // Control after reset
   localparam logic [7:0]  BCT_REG_RST   = 8'h00;   // Flags, enables, priority
   localparam logic [15:0] BCT_CNT_RST   = 16'h0000; // Counter after reset
   localparam logic [2:0]  BCT_PS_RST    = 3'h0;   // Prescaler after reset
   localparam logic [7:0]  BCT_WR_MASK   = 8'hbf;  // Control bits writable by software

   // Prescale codes
   typedef enum logic [1:0] {
      BCT_PS_DIV1 = 2'h0,
      BCT_PS_DIV2 = 2'h1,
      BCT_PS_DIV4 = 2'h2,
      BCT_PS_DIV8 = 2'h3
   } bct_ps_e;

   // APB request as seen by the slave
   typedef struct packed {
      logic        psel;     // Slave select
      logic        penable;  // Access phase
      logic        pwrite;   // Direction
      logic [11:0] paddr;    // Byte address
      logic [31:0] pwdata;   // Write data
   } bct_apb_req_s;

   // Decoded register access strobes, one cycle long
   typedef struct packed {
      logic       wr_low;    // Write of low byte
      logic       wr_high;   // Write of high address
      logic       rd_low;    // Read of low byte
      logic       wr_ctrl;   // Write of control
      logic       wr_flags;  // Write of flags
      logic       wr_ena;    // Write of enables
      logic       wr_prio;   // Write of priority
      logic       wr_gic;    // Write of global control
      logic [7:0] wdata;     // Write byte
   } bct_acc_s;

endpackage

// File: design/bct_prescale.sv
// Prescaler that divides the count clock enable by 1, 2, 4 or 8
`timescale 1ns/1ps
module bct_prescale import bct_pkg::*; (
   input  wire logic       clk,      // System clock
   input  wire logic       rst_n,    // Synchronised reset, active low
   input  wire logic       tick,     // Count clock enable in
   input  wire logic       clr,      // Clear prescaler
   input  wire bct_ps_e    sel,      // Division select
   output logic            tick_out  // Divided enable out
);

   // Whole state of the prescaler
   typedef struct packed {
      logic [2:0] cnt;   // Divider count
   } bct_ps_s;

   bct_ps_s st_q;   // Registered state
   bct_ps_s st_d;   // Next state

   // Terminal count for the selected ratio
   function automatic logic [2:0] bct_term(input bct_ps_e s);
      case (s)
         BCT_PS_DIV1: bct_term = 3'h0;
         BCT_PS_DIV2: bct_term = 3'h1;
         BCT_PS_DIV4: bct_term = 3'h3;
         BCT_PS_DIV8: bct_term = 3'h7;
         default:     bct_term = 3'h0;
      endcase
   endfunction

   // Divided enable is combinational so the counter steps in the tick cycle
   assign tick_out = tick & ~clr & (st_q.cnt == bct_term(sel));

   // Next count
   always_comb begin
      st_d = st_q;
      if (clr) begin
         st_d.cnt = BCT_PS_RST;
      end else if (tick) begin
         st_d.cnt = (st_q.cnt == bct_term(sel)) ? 3'h0 : 3'(st_q.cnt + 3'h1);
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q.cnt <= BCT_PS_RST;
      end else begin
         st_q <= st_d;
      end
   end

endmodule

// File: design/bct_top.sv
// Buffered 16-bit up-counter with wide access mode, overflow flag and APB registers
// Summary of operation
// RULE_01: Wide bit maps high address to buffer
// RULE_02: Low-byte read captures live high byte
// RULE_03: Low-byte write loads high from buffer
// RULE_04: Wide-mode high write never touches live high byte
// RULE_05: High-address write keeps prescaler
// RULE_06: Only low-byte write clears prescaler
// RULE_07: Overflow interrupt needs enable bit zero
// RULE_08: Software uses async external counting for clock
// RULE_09: Software sets high MSB, leaves low alone
// RULE_10: Counting continues during sleep; here only the external source counts, sleep stops instruction ticks
// RULE_11: High address holds counter's upper byte
// RULE_12: Software keeps reserved bit seven clear
// RULE_13: Count up, wrap, latch overflow flag
// RULE_14: Source select: instruction cycle or edge
// RULE_15: Prescale codes divide by 1,2,4,8
// RULE_16: Capture and transfer in access cycle
// RULE_17: Normal mode reaches live high byte
`timescale 1ns/1ps
module bct_top import bct_pkg::*; (
   input  wire logic        sys_clk,     // System clock, 20 MHz
   input  wire logic        nrst,        // Asynchronous reset, active low
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB enable
   input  wire logic        pwrite,      // APB direction
   input  wire logic [11:0] paddr,       // APB byte address
   input  wire logic [31:0] pwdata,     // APB write data
   output logic      [31:0] prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr,     // APB error
   input  wire logic        instr_tick,  // Instruction cycle enable
   input  wire logic        ext_clk_in,  // External or crystal clock level
   input  wire logic        sleep_mode,  // Device in sleep
   input  wire logic        aux_sysclk,  // System clock taken from aux osc
   output logic             irq,         // Overflow interrupt, level
   output logic             irq_high,    // Overflow interrupt is high priority
   output logic             osc_run      // Crystal oscillator enable out
);

   // Whole register state of the block; the reset chain
   // sits apart, as it alone runs on the raw reset
   typedef struct packed {
      logic [15:0] cnt;       // Live counter
      logic [7:0]  hbuf;      // High byte holding buffer
      logic [7:0]  ctrl;      // Counter control
      logic [7:0]  flags;     // Peripheral flags one
      logic [7:0]  ena;       // Peripheral enables one
      logic [7:0]  prio;      // Peripheral priority one
      logic [7:0]  gic;       // Global interrupt control
      logic        ext_prev;  // Last external clock level
      logic [31:0] rdata;     // Read data register
      logic        ready;     // Ready register
      logic        err;       // Error register
      logic        irq;       // Interrupt register
      logic        irq_hi;    // Priority register out
      logic        osc;       // Oscillator enable out
   } bct_top_s;

   // State, next state and wiring between the parts
   bct_top_s     st_q;      // Registered state
   bct_top_s     st_d;      // Next state
   logic [1:0]   rst_sync_q; // Reset release chain
   logic         rst_n;     // Synchronised reset
   bct_apb_req_s req;       // Bundled APB request
   bct_acc_s     acc;       // Access strobes
   logic         hit;       // Mapped address
   logic         fire;      // Access phase
   logic         raw_tick;  // Undivided count enable
   logic         cnt_tick;  // Divided count enable
   logic         wide;      // Wide mode active

   // Only the second flop of the chain is read
   assign rst_n = rst_sync_q[1];
   // Bus pins bundled for the decoder
   assign req   = '{psel: psel, penable: penable, pwrite: pwrite,
                    paddr: paddr, pwdata: pwdata};
   // Wide mode acts from the edge after the control
   // write; that write itself is not affected
   assign wide  = st_q.ctrl[BCT_CTRL_WIDE_BIT];

   // RULE_11 high holding byte
   // Byte shown at the high address
   function automatic logic [7:0] bct_high_view(input logic       w,
                                                 input logic [7:0] hold_b,
                                                 input logic [7:0] live_b);
      bct_high_view = w ? hold_b : live_b;
   endfunction

   // Request of one source: flag and gate
   function automatic logic bct_req(input logic flag, input logic gate);
      bct_req = flag & gate;
   endfunction

   // Bus decoder; strobes last one access cycle,
   // so each transfer acts exactly once
   bct_apb_if u_if (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .req   (req),
      .acc   (acc),
      .hit   (hit),
      .fire  (fire)
   );

   // Count source. Sleep stops instruction ticks only;
   // the external input keeps counting, so overflows
   // keep time while the core is halted. The level is
   // compared with last cycle's: one rise, one step.
   // RULE_14 source select
   // RULE_10 sleep keeps counting
   always_comb begin
      if (st_q.ctrl[BCT_CTRL_SRC_BIT]) begin
         raw_tick = ext_clk_in & ~st_q.ext_prev;
      end else begin
         raw_tick = instr_tick & ~sleep_mode;
      end
      raw_tick = raw_tick & st_q.ctrl[BCT_CTRL_RUN_BIT];
   end

   // Prescaler, cleared only by low-byte writes
   // A clear drops a count in the same cycle
   // A high-byte write keeps its phase
   // RULE_06 low write clears
   // RULE_05 high write keeps
   // RULE_15 division ratios
   bct_prescale u_ps (
      .clk      (sys_clk),
      .rst_n    (rst_n),
      .tick     (raw_tick),
      .clr      (acc.wr_low),
      .sel      (bct_ps_e'(st_q.ctrl[BCT_CTRL_PS_LSB +: 2])),
      .tick_out (cnt_tick)
   );

   // Next state of all registers
   // Section order sets precedence inside one cycle:
   // a low-byte write beats a count,
   // the capture on a low read follows the high write,
   // which never meet in one access phase,
   // and the overflow set follows the write-one clear,
   // so a wrap is never lost.
   always_comb begin
      logic       ovf;    // Counter wraps this cycle
      logic [7:0] rd8;    // Selected read byte
      st_d = st_q;
      ovf = 1'b0;
      rd8 = 8'h00;
      // Keep the external level for edge detection
      st_d.ext_prev = ext_clk_in;

      // RULE_13 count and wrap
      // Add wraps by truncation; wrap seen on old value
      if (cnt_tick) begin
         st_d.cnt = 16'(st_q.cnt + 16'h0001);
         ovf = (st_q.cnt == 16'hffff);
      end

      // Low-byte write; software write takes precedence over a count
      // In wide mode the buffer moves in the same edge,
      // so no count falls between the two halves
      if (acc.wr_low) begin
         st_d.cnt[7:0] = acc.wdata;
         // RULE_03 buffer transfer
         // RULE_16 same cycle
         if (wide) begin
            st_d.cnt[15:8] = st_q.hbuf;
         end
      end

      // High address write; in wide mode it only fills
      // the buffer until the next low-byte write
      if (acc.wr_high) begin
         // RULE_04 buffer only
         // RULE_01 wide decode
         if (wide) begin
            st_d.hbuf = acc.wdata;
         end else begin
            // RULE_17 direct access
            st_d.cnt[15:8] = acc.wdata;
         end
      end

      // In wide mode a low read copies the live high byte in its access cycle, so a later
      // high read matches unless a count carries out of the low byte at that read's setup edge
      // RULE_02 capture on read
      // RULE_16 same cycle
      if (acc.rd_low && wide) begin
         st_d.hbuf = st_q.cnt[15:8];
      end

      // Register writes
      // Control bit 6 always shows the clock source
      // Global control is plain storage, gating nothing
      if (acc.wr_ctrl) begin
         st_d.ctrl = (acc.wdata & BCT_WR_MASK);
      end
      st_d.ctrl[BCT_CTRL_AUX_BIT] = aux_sysclk;
      if (acc.wr_ena) begin
         st_d.ena = acc.wdata;
      end
      if (acc.wr_prio) begin
         st_d.prio = acc.wdata;
      end
      if (acc.wr_gic) begin
         st_d.gic = acc.wdata;
      end

      // Flags: write one clears, overflow set wins
      // Other flag bits have no source in this block
      if (acc.wr_flags) begin
         st_d.flags = st_q.flags & ~acc.wdata;
      end
      // RULE_13 latch overflow
      if (ovf) begin
         st_d.flags[BCT_OVF_BIT] = 1'b1;
      end

      // Read mux on the setup address; unmapped reads zero
      case (paddr)
         BCT_ADDR_LOW:   rd8 = st_q.cnt[7:0];
         // RULE_11 high holding byte
         BCT_ADDR_HIGH:  rd8 = bct_high_view(wide, st_q.hbuf, st_q.cnt[15:8]);
         BCT_ADDR_CTRL:  rd8 = st_q.ctrl;
         BCT_ADDR_FLAGS: rd8 = st_q.flags;
         BCT_ADDR_ENA:   rd8 = st_q.ena;
         BCT_ADDR_PRIO:  rd8 = st_q.prio;
         BCT_ADDR_GIC:   rd8 = st_q.gic;
         default:        rd8 = 8'h00;
      endcase

      // Answer in the first access cycle; ready then drops after one cycle and stays low until the next setup
      // Read data is caught at the setup edge and held
      // until the next setup, over the access cycle
      st_d.ready = psel & ~penable;
      st_d.err   = psel & ~penable & ~hit;
      if (psel && !penable) begin
         st_d.rdata = {24'h000000, rd8};
      end

      // Built from next values: request rises with flag
      // RULE_07 enable gates request
      st_d.irq = bct_req(st_d.flags[BCT_OVF_BIT], st_d.ena[BCT_OVF_BIT]);
      // Priority only ever comes with the request
      st_d.irq_hi = bct_req(st_d.irq, st_d.prio[BCT_OVF_BIT]);
      // Oscillator enable mirrors the control bit
      st_d.osc = st_d.ctrl[BCT_CTRL_OSC_BIT];
   end

   // Reset release chain, on the raw reset
   // Assertion is immediate; release reaches the
   // other flops two edges later, on a clock edge,
   // so none of them races the raw release
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   // Remaining state on the synchronised reset
   // All of it leaves reset on the same edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q.cnt      <= BCT_CNT_RST;
         st_q.hbuf     <= BCT_REG_RST;
         st_q.ctrl     <= BCT_CTRL_RST;
         st_q.flags    <= BCT_REG_RST;
         st_q.ena      <= BCT_REG_RST;
         st_q.prio     <= BCT_REG_RST;
         st_q.gic      <= BCT_REG_RST;
         st_q.ext_prev <= 1'b0;
         st_q.rdata    <= 32'h00000000;
         st_q.ready    <= 1'b0;
         st_q.err      <= 1'b0;
         st_q.irq      <= 1'b0;
         st_q.irq_hi   <= 1'b0;
         st_q.osc      <= 1'b0;
      end else begin
         st_q.cnt      <= st_d.cnt;
         st_q.hbuf     <= st_d.hbuf;
         st_q.ctrl     <= st_d.ctrl;
         st_q.flags    <= st_d.flags;
         st_q.ena      <= st_d.ena;
         st_q.prio     <= st_d.prio;
         st_q.gic      <= st_d.gic;
         st_q.ext_prev <= st_d.ext_prev;
         st_q.rdata    <= st_d.rdata;
         st_q.ready    <= st_d.ready;
         st_q.err      <= st_d.err;
         st_q.irq      <= st_d.irq;
         st_q.irq_hi   <= st_d.irq_hi;
         st_q.osc      <= st_d.osc;
      end
   end

   // Each output is a state flop, no logic after it
   assign prdata   = st_q.rdata;
   assign pready   = st_q.ready;
   assign pslverr  = st_q.err;
   assign irq      = st_q.irq;
   assign irq_high = st_q.irq_hi;
   assign osc_run  = st_q.osc;

endmodule

// File: verif/bct_top_asserts.sv
// Port checker of the buffered counter
`timescale 1ns/1ps
module bct_top_asserts import bct_pkg::*; (
   input wire logic        sys_clk,  // System clock
   input wire logic        nrst,     // Reset, active low
   input wire logic        psel,     // APB select
   input wire logic        penable,  // APB enable
   input wire logic        pwrite,   // APB direction
   input wire logic [11:0] paddr,    // APB address
   input wire logic [31:0] pwdata,   // APB write data
   input wire logic [31:0] prdata,   // APB read data
   input wire logic        pready,   // APB ready
   input wire logic        pslverr,  // APB error
   input wire logic        irq,      // Overflow interrupt
   input wire logic        irq_high, // High priority interrupt
   input wire logic        osc_run   // Oscillator enable
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic done;   // Transfer completes at this edge
   logic mapped; // Address names a register
   logic ena_q;  // Shadow of the overflow enable
   assign done = psel && penable && pready;
   assign mapped = (paddr <= BCT_ADDR_GIC) && (paddr[1:0] == 2'h0);
   // Follow the enable bit as software writes it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ena_q <= 1'b0;
      end else if (done && pwrite && paddr == BCT_ADDR_ENA) begin
         ena_q <= pwdata[BCT_OVF_BIT];
      end
   end
   sequence s_setup; psel && !penable; endsequence
   sequence s_ctrl_wr; done && pwrite && paddr == BCT_ADDR_CTRL; endsequence
   sequence s_mask; done && pwrite && paddr == BCT_ADDR_ENA && !pwdata[0]; endsequence
   property p_ready_first; s_setup |=> pready; endproperty
   property p_ready_once; pready |=> !pready; endproperty
   property p_err_map; done |-> pslverr == !mapped; endproperty
   property p_upper_zero; done && !pwrite |-> prdata[31:8] == 24'h0; endproperty
   property p_irq_ena; irq |-> ena_q; endproperty
   property p_irq_prio; irq_high |-> irq; endproperty
   property p_irq_off; s_mask |-> ##2 !irq; endproperty
   property p_osc_copy; s_ctrl_wr |-> ##2 osc_run == $past(pwdata[3], 2); endproperty
   a_ready_first: assert property (p_ready_first) else $error("ready late");
   a_ready_once: assert property (p_ready_once) else $error("ready too long");
   a_err_map: assert property (p_err_map) else $error("bad error flag");
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
   a_irq_ena: assert property (p_irq_ena) else $error("irq while disabled");
   a_irq_prio: assert property (p_irq_prio) else $error("priority alone");
   a_irq_off: assert property (p_irq_off) else $error("irq not masked");
   a_osc_copy: assert property (p_osc_copy) else $error("osc copy wrong");
endmodule

// File: verif/bct_top_tb.sv
// Self-checking bench of the buffered counter
`timescale 1ns/1ps
module bct_top_tb import bct_pkg::*;;
   logic        sys_clk = 1'b0;    // Clock
   logic        nrst = 1'b0;       // Reset, active low
   logic        psel = 1'b0;       // APB select
   logic        penable = 1'b0;    // APB enable
   logic        pwrite = 1'b0;     // APB direction
   logic [11:0] paddr = 12'h000;   // APB address
   logic [31:0] pwdata = 32'h0;    // APB write data
   logic        instr_tick = 1'b0; // Instruction tick
   logic        ext_clk_in = 1'b0; // External clock
   logic        sleep_mode = 1'b0; // Sleep
   logic        aux_sysclk = 1'b0; // Aux clock status
   logic [31:0] prdata;            // Read data
   logic        pready;            // Ready
   logic        pslverr;           // Error
   logic        irq;               // Interrupt
   logic        irq_high;          // Priority interrupt
   logic        osc_run;           // Oscillator enable
   int          fail_count = 0;    // Mismatches
   int          n_tests = 0;       // Comparisons
   logic [9:0]  notes[$];          // Write, error, byte per transfer
   logic [9:0]  nt;                // Note under check
   logic [7:0]  r;                 // Random byte
   logic [11:0] regs [7] = '{BCT_ADDR_LOW, BCT_ADDR_HIGH, BCT_ADDR_CTRL,
      BCT_ADDR_FLAGS, BCT_ADDR_ENA, BCT_ADDR_PRIO, BCT_ADDR_GIC}; // Mapped places
   // Free-running 20 MHz clock
   always #25 sys_clk = ~sys_clk;
   bct_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .instr_tick(instr_tick),
      .ext_clk_in(ext_clk_in), .sleep_mode(sleep_mode), .aux_sysclk(aux_sysclk),
      .irq(irq), .irq_high(irq_high), .osc_run(osc_run));
   // Compare one value, count it
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic conclude();
      if (fail_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // One APB transfer; on a read d is the byte expected
   task automatic xf(logic w, logic [11:0] a, logic [7:0] d, logic e = 1'b0);
      int k;
      notes.push_back({w, e, d});
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      // Bounded wait for the answer
      if (pready !== 1'b1) begin
         fail_count++;
         conclude();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Count steps: one instruction tick each, external edge if asked
   task automatic tick(int n, logic ext);
      repeat (n) begin
         @(posedge sys_clk);
         instr_tick <= 1'b1;
         ext_clk_in <= ext;
         @(posedge sys_clk);
         instr_tick <= 1'b0;
         repeat (2) @(posedge sys_clk);
         ext_clk_in <= 1'b0;
         repeat (2) @(posedge sys_clk);
      end
   endtask
   // Let registered outputs land
   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #5;
   endtask
   // Take the oldest note for each completed transfer
   always @(posedge sys_clk) begin
      if (psel && penable && pready === 1'b1) begin
         if (notes.size() == 0) begin
            fail_count++;
         end else begin
            nt = notes.pop_front();
            chk("pslverr", {7'h0, pslverr}, {7'h0, nt[8]});
            if (!nt[9]) begin
               chk("prdata", prdata[7:0], nt[7:0]);
            end
         end
      end
   end
   // Main sequence
   initial begin
      r = 8'($urandom(32'h0467)) | 8'h80;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      foreach (regs[i]) xf(0, regs[i], 8'h00);
      xf(0, 12'h01c, 8'h00, 1'b1);
      xf(1, 12'h020, 8'hff, 1'b1);
      // Normal mode reaches the live high byte
      xf(1, BCT_ADDR_HIGH, r);
      xf(0, BCT_ADDR_HIGH, r);
      xf(0, BCT_ADDR_LOW, 8'h00);
      // Wide mode: high address is a buffer until a low write
      xf(1, BCT_ADDR_CTRL, 8'h80);
      xf(1, BCT_ADDR_HIGH, 8'h5a);
      xf(0, BCT_ADDR_HIGH, 8'h5a);
      xf(1, BCT_ADDR_CTRL, 8'h00);
      xf(0, BCT_ADDR_HIGH, r);
      xf(1, BCT_ADDR_CTRL, 8'h80);
      xf(1, BCT_ADDR_LOW, 8'h3c);
      xf(1, BCT_ADDR_HIGH, 8'h77);
      xf(0, BCT_ADDR_LOW, 8'h3c);
      xf(0, BCT_ADDR_HIGH, 8'h5a);
      xf(1, BCT_ADDR_CTRL, 8'h00);
      xf(0, BCT_ADDR_HIGH, 8'h5a);
      // Sixteen ticks through every prescale code
      for (int p = 0; p < 4; p++) begin
         xf(1, BCT_ADDR_CTRL, 8'h00);
         xf(1, BCT_ADDR_LOW, 8'h00);
         xf(1, BCT_ADDR_CTRL, 8'(p << 4) | 8'h01);
         tick(16, 1'b0);
         xf(0, BCT_ADDR_LOW, 8'(16 >> p));
      end
      // Prescaler kept by high writes, cleared by low writes
      xf(1, BCT_ADDR_LOW, 8'h00);
      tick(5, 1'b0);
      xf(1, BCT_ADDR_HIGH, 8'h00);
      tick(3, 1'b0);
      xf(0, BCT_ADDR_LOW, 8'h01);
      tick(5, 1'b0);
      xf(1, BCT_ADDR_LOW, 8'h00);
      tick(4, 1'b0);
      xf(0, BCT_ADDR_LOW, 8'h00);
      // External source ignores ticks and keeps counting in sleep
      xf(1, BCT_ADDR_CTRL, 8'h0f);
      xf(1, BCT_ADDR_LOW, 8'h00);
      chk("osc_run", {7'h0, osc_run}, 8'h01);
      tick(3, 1'b0);
      xf(0, BCT_ADDR_LOW, 8'h00);
      sleep_mode <= 1'b1;
      aux_sysclk <= 1'b1;
      tick(6, 1'b1);
      xf(0, BCT_ADDR_LOW, 8'h06);
      xf(0, BCT_ADDR_CTRL, 8'h4f);
      sleep_mode <= 1'b0;
      // Wrap from the top count, then enable, priority, mask, clear
      xf(1, BCT_ADDR_CTRL, 8'h00);
      xf(1, BCT_ADDR_HIGH, 8'hff);
      xf(1, BCT_ADDR_LOW, 8'hfe);
      xf(1, BCT_ADDR_CTRL, 8'h01);
      tick(1, 1'b0);
      xf(0, BCT_ADDR_FLAGS, 8'h00);
      tick(1, 1'b0);
      xf(1, BCT_ADDR_CTRL, 8'h00);
      xf(0, BCT_ADDR_FLAGS, 8'h01);
      xf(0, BCT_ADDR_HIGH, 8'h00);
      // Time-base preload: set only the top bit, keep the low byte
      xf(1, BCT_ADDR_HIGH, 8'h80);
      xf(0, BCT_ADDR_LOW, 8'h00);
      xf(0, BCT_ADDR_HIGH, 8'h80);
      settle();
      chk("irq", {7'h0, irq}, 8'h00);
      xf(1, BCT_ADDR_ENA, 8'h01);
      xf(1, BCT_ADDR_PRIO, 8'h01);
      settle();
      chk("irq", {7'h0, irq}, 8'h01);
      chk("irq_high", {7'h0, irq_high}, 8'h01);
      xf(1, BCT_ADDR_ENA, 8'h00);
      settle();
      chk("irq", {7'h0, irq}, 8'h00);
      xf(1, BCT_ADDR_ENA, 8'h01);
      xf(1, BCT_ADDR_FLAGS, 8'h01);
      settle();
      chk("irq", {7'h0, irq}, 8'h00);
      xf(0, BCT_ADDR_FLAGS, 8'h00);
      conclude();
   end
endmodule
bind bct_top bct_top_asserts chk_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
   .irq_high(irq_high), .osc_run(osc_run));
